//--- common/scpm_params.svh
// constants for the ssd command and power manager
`ifndef SCPM_PARAMS_SVH
`define SCPM_PARAMS_SVH
`define SCPM_OPC_TRIM 8'h06
`define SCPM_OPC_RD_SECT 8'h20
`define SCPM_OPC_RD_SECT_NR 8'h21
`define SCPM_OPC_RD_SECT_EXT 8'h24
`define SCPM_OPC_RD_DMA_EXT 8'h25
`define SCPM_OPC_RD_NMAX_EXT 8'h27
`define SCPM_OPC_WR_SECT 8'h30
`define SCPM_OPC_WR_SECT_EXT 8'h34
`define SCPM_OPC_WR_DMA_EXT 8'h35
`define SCPM_OPC_RD_DMA 8'hC8
`define SCPM_OPC_RD_DMA_NR 8'hC9
`define SCPM_OPC_WR_DMA 8'hCA
`define SCPM_OPC_SET_FEAT 8'hEF
`define SCPM_OPC_SEC_ERASE 8'hF4
`define SCPM_ECC_MAX_BITS 8'h48
`define SCPM_ECC_UNIT_BYTES 1024
`define SCPM_SECTOR_SHIFT 9
`define SCPM_ERASE_WORD 32'hFFFF_FFFF
`define SCPM_GRP_RESET 1'h1
`define SCPM_CLK_MHZ 250
`define SCPM_PARTIAL_EXIT_US 10
`define SCPM_SLUMBER_EXIT_MS 10
`define SCPM_DEVSLP_EXIT_MS 20
`define SCPM_PARTIAL_EXIT_CYC (`SCPM_PARTIAL_EXIT_US * `SCPM_CLK_MHZ - 1)
`define SCPM_SLUMBER_EXIT_CYC (`SCPM_SLUMBER_EXIT_MS * 1000 * `SCPM_CLK_MHZ - 1)
`define SCPM_DEVSLP_EXIT_CYC (`SCPM_DEVSLP_EXIT_MS * 1000 * `SCPM_CLK_MHZ)
`endif

//--- common/scpm_pkg.sv
// types for the ssd command and power manager
`default_nettype none
package scpm_pkg;
	typedef enum logic [2:0] {
		ENG_IDLE = 3'h0,
		ENG_ISSUE = 3'h1,
		ENG_WAIT = 3'h2,
		ENG_RETRY = 3'h3,
		ENG_SEC = 3'h4,
		ENG_SEC_END = 3'h5
	} scpm_eng_type;
	typedef enum logic [2:0] {
		JOB_WRITE = 3'h0,
		JOB_READ = 3'h1,
		JOB_TRIM = 3'h2,
		JOB_SEC = 3'h3,
		JOB_STATIC = 3'h4
	} scpm_job_type;
	typedef enum logic [1:0] {
		FOP_READ = 2'h0,
		FOP_PROG = 2'h1,
		FOP_ERASE = 2'h2,
		FOP_MOVE = 2'h3
	} scpm_fop_type;
	typedef enum logic [2:0] {
		PWR_ACTIVE = 3'h0,
		PWR_PARTIAL = 3'h1,
		PWR_SLUMBER = 3'h2,
		PWR_DEVSLP = 3'h3,
		PWR_WAKE = 3'h4
	} scpm_pwr_type;
endpackage
`default_nettype wire

//--- hdl/scpm_core.sv
// ssd command decoder, flash job engine and link power manager
`include "scpm_params.svh"
`default_nettype none
module scpm_core
	import scpm_pkg::*;
#(
	parameter int NBLK = 16,
	parameter int BW = $clog2(NBLK),
	parameter int WW = 8,
	parameter int BLK_SHIFT = 8,
	parameter int FDEPTH = 16,
	parameter int GROUP_WORDS = 8,
	parameter logic [WW-1:0] STATIC_THR = 8'h10,
	parameter logic [15:0] DIPM_IDLE = 16'h0400,
	parameter logic [47:0] NATIVE_MAX_LBA = 48'h0000_01DD_40AF,
	parameter logic [22:0] PARTIAL_SETTLE = 23'h00_0040,
	parameter logic [22:0] SLUMBER_SETTLE = 23'h00_0400,
	parameter logic [22:0] DEVSLP_SETTLE = 23'h00_0800,
	parameter logic [22:0] SLUMBER_EXIT_CYC = 23'(`SCPM_SLUMBER_EXIT_CYC),
	parameter logic [22:0] DEVSLP_EXIT_CYC = 23'(`SCPM_DEVSLP_EXIT_CYC)
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [47:0] cmd_lba,
	input wire logic [15:0] cmd_count,
	output logic cmd_ready,
	output logic cmd_abort,
	output logic pio_rd_start,
	output logic dma_rd_start,
	output logic wr_start,
	output logic [24:0] xfer_bytes,
	output logic [56:0] xfer_addr,
	output logic native_max_valid,
	output logic [47:0] native_max_lba,
	output logic trim_done,
	output logic sec_erase_done,
	output logic defaults_restored,
	input wire logic wr_valid,
	input wire logic [31:0] wr_data,
	input wire logic wr_last,
	output logic wr_ready,
	output logic wr_ack,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic rd_corrected,
	output logic rd_uncorr,
	input wire logic fbad_valid,
	input wire logic [BW-1:0] fbad_blk,
	output logic fl_req_valid,
	output logic [1:0] fl_req_op,
	output logic [BW-1:0] fl_req_blk,
	output logic [31:0] fl_req_data,
	input wire logic fl_req_ready,
	input wire logic fl_done,
	input wire logic fl_fail,
	input wire logic [7:0] fl_err_bits,
	input wire logic [31:0] fl_rd_data,
	input wire logic fl_congested,
	input wire logic hipm_partial,
	input wire logic hipm_slumber,
	input wire logic dipm_en,
	input wire logic host_wake,
	input wire logic dev_wake,
	input wire logic devslp_pin,
	output logic phy_pwr_on,
	output logic phy_tx_en,
	output logic phy_rx_en,
	output logic phy_ready,
	output logic [2:0] link_state
);
	localparam int FAW = $clog2(FDEPTH);
	localparam logic [FAW:0] GRP = (FAW+1)'(GROUP_WORDS);
	localparam logic [22:0] PARTIAL_EXIT_CYC = 23'(`SCPM_PARTIAL_EXIT_CYC);
	typedef struct packed {
		scpm_eng_type eng;
		scpm_job_type job;
		scpm_fop_type op;
		logic [BW-1:0] blk;
		logic [31:0] data;
		logic last;
		logic [BW-1:0] scan;
		logic [NBLK-1:0] bad;
		logic [NBLK-1:0][WW-1:0] wear;
		logic [FAW:0] lastq;
		logic grp;
		logic [8:0] pulse;
		logic [31:0] rd_data;
		logic rd_corr;
		logic rd_bad;
		logic [24:0] xbytes;
		logic [56:0] xaddr;
		scpm_pwr_type pwr;
		scpm_pwr_type tgt;
		logic [22:0] pcnt;
		logic [15:0] idle;
		logic [1:0] dsync;
	} scpm_core_st_type;
	scpm_core_st_type s_ff;
	scpm_core_st_type nxt_s;
	logic f_valid;
	logic f_pop;
	logic [32:0] f_data;
	logic [FAW:0] f_cnt;
	logic [BW-1:0] alloc;
	logic [BW-1:0] hot;
	logic alloc_ok;
	logic [WW-1:0] min_w;
	logic [WW-1:0] max_w;
	logic can_pop;
	logic devslp;

	scpm_fifo #(.W(33), .DEPTH(FDEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(wr_valid),
		.in_data({wr_last, wr_data}),
		.in_ready(wr_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_pop),
		.count(f_cnt)
	);

	// bad blocks are skipped so data never lands in them
	always_comb
	begin
		min_w = '1;
		max_w = '0;
		alloc = '0;
		hot = '0;
		alloc_ok = 1'b0;
		for (int i = 0; i < NBLK; i++)
		begin
			if (!s_ff.bad[i])
			begin
				if (!alloc_ok || s_ff.wear[i] < min_w)
				begin
					min_w = s_ff.wear[i];
					alloc = BW'(i);
				end
				if (s_ff.wear[i] >= max_w)
				begin
					max_w = s_ff.wear[i];
					hot = BW'(i);
				end
				alloc_ok = 1'b1;
			end
		end
	end

	assign devslp = s_ff.dsync[1];
	assign cmd_ready = s_ff.eng == ENG_IDLE && s_ff.pwr == PWR_ACTIVE;
	// a pending last word lets a short write drain while congested
	assign can_pop = f_valid && alloc_ok && (!s_ff.grp || !fl_congested ||
		f_cnt >= GRP || s_ff.lastq != '0);
	assign f_pop = s_ff.eng == ENG_IDLE && !cmd_valid && can_pop;

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.pulse = '0;
		nxt_s.dsync = {s_ff.dsync[0], devslp_pin};
		nxt_s.lastq = s_ff.lastq + {{FAW{1'b0}}, wr_valid && wr_ready && wr_last}
			- {{FAW{1'b0}}, f_pop && f_data[32]};
		if (fbad_valid)
			nxt_s.bad[fbad_blk] = 1'b1;
		case (s_ff.eng)
			ENG_IDLE:
				if (cmd_valid && cmd_ready)
				begin
					nxt_s.xbytes = {cmd_count, 9'h000};
					nxt_s.xaddr = {cmd_lba, 9'h000};
					nxt_s.blk = cmd_lba[BLK_SHIFT +: BW];
					case (cmd_opcode)
						`SCPM_OPC_RD_SECT, `SCPM_OPC_RD_SECT_NR,
						`SCPM_OPC_RD_SECT_EXT,
						`SCPM_OPC_RD_DMA_EXT, `SCPM_OPC_RD_DMA,
						`SCPM_OPC_RD_DMA_NR:
						begin
							nxt_s.pulse[0] = cmd_opcode[7:4] == 4'h2 &&
								cmd_opcode != `SCPM_OPC_RD_DMA_EXT;
							nxt_s.pulse[1] = !nxt_s.pulse[0];
							nxt_s.job = JOB_READ;
							nxt_s.op = FOP_READ;
							nxt_s.eng = ENG_ISSUE;
						end
						`SCPM_OPC_WR_SECT, `SCPM_OPC_WR_SECT_EXT,
						`SCPM_OPC_WR_DMA_EXT, `SCPM_OPC_WR_DMA:
							nxt_s.pulse[2] = 1'b1;
						`SCPM_OPC_RD_NMAX_EXT:
							nxt_s.pulse[3] = 1'b1;
						`SCPM_OPC_SET_FEAT:
							nxt_s.grp = cmd_count[0];
						`SCPM_OPC_TRIM:
						begin
							nxt_s.job = JOB_TRIM;
							nxt_s.op = FOP_ERASE;
							if (s_ff.bad[cmd_lba[BLK_SHIFT +: BW]])
								nxt_s.pulse[5] = 1'b1;
							else
								nxt_s.eng = ENG_ISSUE;
						end
						`SCPM_OPC_SEC_ERASE:
						begin
							nxt_s.job = JOB_SEC;
							nxt_s.scan = '0;
							nxt_s.eng = ENG_SEC;
						end
						default:
							nxt_s.pulse[4] = 1'b1;
					endcase
				end
				else if (f_pop)
				begin
					nxt_s.job = JOB_WRITE;
					nxt_s.op = FOP_PROG;
					nxt_s.blk = alloc;
					nxt_s.data = f_data[31:0];
					nxt_s.last = f_data[32];
					nxt_s.eng = ENG_ISSUE;
				end
				else if (!f_valid && alloc_ok && alloc != hot &&
					max_w - min_w >= STATIC_THR)
				begin
					// cold data parks in the least worn block; move it
					nxt_s.job = JOB_STATIC;
					nxt_s.op = FOP_MOVE;
					nxt_s.blk = alloc;
					nxt_s.data = {{(32-BW){1'b0}}, hot};
					nxt_s.eng = ENG_ISSUE;
				end
			ENG_ISSUE:
				if (fl_req_ready)
					nxt_s.eng = ENG_WAIT;
			ENG_WAIT:
				if (fl_done)
				begin
					nxt_s.eng = ENG_IDLE;
					if (s_ff.op != FOP_READ && s_ff.wear[s_ff.blk] != '1)
						nxt_s.wear[s_ff.blk] = s_ff.wear[s_ff.blk] + 1'b1;
					if (fl_fail && s_ff.op != FOP_READ)
						nxt_s.bad[s_ff.blk] = 1'b1;
					case (s_ff.job)
						JOB_WRITE:
							if (fl_fail)
								nxt_s.eng = ENG_RETRY;
							else
								nxt_s.pulse[7] = s_ff.last;
						JOB_READ:
						begin
							nxt_s.pulse[8] = 1'b1;
							nxt_s.rd_bad = fl_err_bits > `SCPM_ECC_MAX_BITS;
							if (nxt_s.rd_bad)
								nxt_s.rd_data = '0;
							else
								nxt_s.rd_data = fl_rd_data;
							nxt_s.rd_corr = !nxt_s.rd_bad && fl_err_bits != '0;
						end
						JOB_TRIM:
							nxt_s.pulse[5] = 1'b1;
						JOB_SEC:
						begin
							nxt_s.scan = s_ff.scan + 1'b1;
							nxt_s.eng = (s_ff.scan == BW'(NBLK - 1)) ?
								ENG_SEC_END : ENG_SEC;
						end
						default:
							nxt_s.eng = ENG_IDLE;
					endcase
				end
			ENG_RETRY:
				// with every block bad the word waits here for good
				if (alloc_ok)
				begin
					nxt_s.blk = alloc;
					nxt_s.eng = ENG_ISSUE;
				end
			ENG_SEC:
				if (s_ff.bad[s_ff.scan])
				begin
					nxt_s.scan = s_ff.scan + 1'b1;
					if (s_ff.scan == BW'(NBLK - 1))
						nxt_s.eng = ENG_SEC_END;
				end
				else
				begin
					nxt_s.op = FOP_PROG;
					nxt_s.blk = s_ff.scan;
					nxt_s.data = `SCPM_ERASE_WORD;
					nxt_s.eng = ENG_ISSUE;
				end
			ENG_SEC_END:
			begin
				nxt_s.grp = `SCPM_GRP_RESET;
				nxt_s.pulse[6] = 1'b1;
				nxt_s.eng = ENG_IDLE;
			end
			default:
				nxt_s.eng = ENG_IDLE;
		endcase
		case (s_ff.pwr)
			PWR_ACTIVE:
			begin
				if (s_ff.eng == ENG_IDLE && !f_valid && !cmd_valid)
					nxt_s.idle = (s_ff.idle == '1) ? s_ff.idle : s_ff.idle + 1'b1;
				else
					nxt_s.idle = '0;
				if (devslp)
					nxt_s.pwr = PWR_DEVSLP;
				else if (hipm_slumber)
					nxt_s.pwr = PWR_SLUMBER;
				else if (hipm_partial ||
					(dipm_en && s_ff.idle >= DIPM_IDLE))
					nxt_s.pwr = PWR_PARTIAL;
			end
			PWR_PARTIAL, PWR_SLUMBER:
			begin
				nxt_s.idle = '0;
				if (devslp)
					nxt_s.pwr = PWR_DEVSLP;
				else if (host_wake || dev_wake)
				begin
					nxt_s.tgt = s_ff.pwr;
					nxt_s.pcnt = (s_ff.pwr == PWR_PARTIAL) ?
						PARTIAL_SETTLE : SLUMBER_SETTLE;
					nxt_s.pwr = PWR_WAKE;
				end
			end
			PWR_DEVSLP:
				if (!devslp)
				begin
					nxt_s.tgt = PWR_DEVSLP;
					nxt_s.pcnt = DEVSLP_SETTLE;
					nxt_s.pwr = PWR_WAKE;
				end
			PWR_WAKE:
			begin
				nxt_s.pcnt = s_ff.pcnt - 1'b1;
				if (s_ff.pcnt <= 23'h00_0001)
					nxt_s.pwr = PWR_ACTIVE;
			end
			default:
				nxt_s.pwr = PWR_ACTIVE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			s_ff <= '0;
			s_ff.grp <= `SCPM_GRP_RESET;
		end
		else
			s_ff <= nxt_s;
	end

	assign pio_rd_start = s_ff.pulse[0];
	assign dma_rd_start = s_ff.pulse[1];
	assign wr_start = s_ff.pulse[2];
	assign native_max_valid = s_ff.pulse[3];
	assign native_max_lba = NATIVE_MAX_LBA;
	assign cmd_abort = s_ff.pulse[4];
	assign trim_done = s_ff.pulse[5];
	assign sec_erase_done = s_ff.pulse[6];
	assign defaults_restored = s_ff.pulse[6];
	assign wr_ack = s_ff.pulse[7];
	assign rd_valid = s_ff.pulse[8] && !rd_uncorr;
	// failure is flagged on its own bit: zero is a legal data word
	assign rd_uncorr = s_ff.pulse[8] && s_ff.rd_bad;
	assign rd_data = s_ff.rd_data;
	assign rd_corrected = s_ff.pulse[8] && s_ff.rd_corr;
	assign xfer_bytes = s_ff.xbytes;
	assign xfer_addr = s_ff.xaddr;
	assign fl_req_valid = s_ff.eng == ENG_ISSUE;
	assign fl_req_op = s_ff.op;
	assign fl_req_blk = s_ff.blk;
	assign fl_req_data = s_ff.data;
	assign phy_pwr_on = s_ff.pwr != PWR_DEVSLP;
	assign phy_tx_en = s_ff.pwr == PWR_ACTIVE;
	assign phy_rx_en = s_ff.pwr == PWR_ACTIVE;
	assign phy_ready = s_ff.pwr == PWR_ACTIVE;
	assign link_state = s_ff.pwr;

	logic [22:0] wake_age;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			wake_age <= '0;
		else if (s_ff.pwr == PWR_WAKE)
			wake_age <= wake_age + 1'b1;
		else
			wake_age <= '0;
	end
	abort_unknown_a: assert property (@(posedge core_clk) disable iff (rst)
		cmd_valid && cmd_ready && cmd_opcode == 8'h00 |=> cmd_abort &&
		!pio_rd_start && !dma_rd_start && s_ff.eng == ENG_IDLE)
		else $error("unknown opcode not aborted");
	pio_start_a: assert property (@(posedge core_clk) disable iff (rst)
		cmd_valid && cmd_ready && cmd_opcode == `SCPM_OPC_RD_SECT_NR |=>
		pio_rd_start && !dma_rd_start ##1 fl_req_valid)
		else $error("pio read not started");
	dma_start_a: assert property (@(posedge core_clk) disable iff (rst)
		cmd_valid && cmd_ready && cmd_opcode == `SCPM_OPC_RD_DMA_EXT |=>
		dma_rd_start && !pio_rd_start) else $error("dma read not started");
	sector_size_a: assert property (@(posedge core_clk) disable iff (rst)
		pio_rd_start || dma_rd_start |-> xfer_bytes ==
		{$past(cmd_count), 9'h000}) else $error("length not in sectors");
	native_max_a: assert property (@(posedge core_clk) disable iff (rst)
		cmd_valid && cmd_ready && cmd_opcode == `SCPM_OPC_RD_NMAX_EXT |=>
		native_max_valid && native_max_lba == NATIVE_MAX_LBA)
		else $error("native max not returned");
	ecc_limit_a: assert property (@(posedge core_clk) disable iff (rst)
		s_ff.eng == ENG_WAIT && s_ff.job == JOB_READ && fl_done &&
		fl_err_bits <= 8'h48 |=> rd_data == $past(fl_rd_data))
		else $error("correctable read lost");
	uncorr_a: assert property (@(posedge core_clk) disable iff (rst)
		s_ff.eng == ENG_WAIT && s_ff.job == JOB_READ && fl_done &&
		fl_err_bits > 8'h48 |=> rd_data == '0 && !rd_valid && rd_uncorr)
		else $error("uncorrectable read passed data");
	bad_skip_a: assert property (@(posedge core_clk) disable iff (rst)
		fl_req_valid && (s_ff.job == JOB_WRITE || s_ff.job == JOB_SEC) |->
		!s_ff.bad[s_ff.blk]) else $error("data sent to bad block");
	wear_min_a: assert property (@(posedge core_clk) disable iff (rst)
		fl_req_valid && s_ff.job == JOB_WRITE && !$past(fl_req_valid) |->
		s_ff.wear[s_ff.blk] == min_w) else $error("write not least worn");
	ack_commit_a: assert property (@(posedge core_clk) disable iff (rst)
		wr_ack |-> $past(fl_done && !fl_fail && s_ff.eng == ENG_WAIT &&
		s_ff.last)) else $error("write ack before commit");
	group_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		f_pop && fl_congested && s_ff.grp |-> f_cnt >= GRP ||
		s_ff.lastq != '0) else $error("congested write not grouped");
	sec_fill_a: assert property (@(posedge core_clk) disable iff (rst)
		fl_req_valid && s_ff.job == JOB_SEC |-> fl_req_data == 32'hFFFF_FFFF
		&& fl_req_op == FOP_PROG) else $error("secure erase pattern wrong");
	trim_erase_a: assert property (@(posedge core_clk) disable iff (rst)
		fl_req_valid && s_ff.job == JOB_TRIM |-> fl_req_op == FOP_ERASE)
		else $error("trim not erasing");
	active_phy_a: assert property (@(posedge core_clk) disable iff (rst)
		link_state == PWR_ACTIVE |-> phy_ready && phy_tx_en && phy_rx_en &&
		phy_pwr_on) else $error("active phy not ready");
	partial_exit_a: assert property (@(posedge core_clk) disable iff (rst)
		s_ff.pwr == PWR_WAKE && s_ff.tgt == PWR_PARTIAL |->
		wake_age < PARTIAL_EXIT_CYC) else $error("partial exit too slow");
	slumber_exit_a: assert property (@(posedge core_clk) disable iff (rst)
		s_ff.pwr == PWR_WAKE && s_ff.tgt == PWR_SLUMBER |->
		wake_age < SLUMBER_EXIT_CYC) else $error("slumber exit too slow");
	devslp_exit_a: assert property (@(posedge core_clk) disable iff (rst)
		s_ff.pwr == PWR_WAKE && s_ff.tgt == PWR_DEVSLP |->
		wake_age < DEVSLP_EXIT_CYC) else $error("device sleep exit too slow");
endmodule
`default_nettype wire

//--- hdl/scpm_fifo.sv
// write data fifo with valid/ready on both sides
`default_nettype none
module scpm_fifo #(
	parameter int W = 33,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	output logic [AW:0] count
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} scpm_fifo_st_type;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	scpm_fifo_st_type s_ff;
	scpm_fifo_st_type nxt_s;
	logic push;
	logic pop;
	assign in_ready = s_ff.cnt != FULL;
	assign out_valid = s_ff.cnt != '0;
	assign out_data = s_ff.mem[s_ff.rp];
	assign count = s_ff.cnt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb
	begin
		nxt_s = s_ff;
		if (push)
		begin
			nxt_s.mem[s_ff.wp] = in_data;
			nxt_s.wp = (s_ff.wp == AW'(DEPTH - 1)) ? '0 : s_ff.wp + 1'b1;
		end
		if (pop)
			nxt_s.rp = (s_ff.rp == AW'(DEPTH - 1)) ? '0 : s_ff.rp + 1'b1;
		if (push && !pop)
			nxt_s.cnt = s_ff.cnt + 1'b1;
		else if (pop && !push)
			nxt_s.cnt = s_ff.cnt - 1'b1;
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	fifo_bound_a: assert property (@(posedge core_clk) disable iff (rst)
		s_ff.cnt <= FULL) else $error("fifo count past depth");
endmodule
`default_nettype wire

//--- tb/scpm_core_tb.sv
// self-checking bench for the command and power manager
`default_nettype none
module scpm_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst, cmd_valid, wr_valid, wr_last, fbad_valid, slow;
	logic hipm_partial, hipm_slumber, dipm_en, host_wake, dev_wake;
	logic devslp_pin, cmd_ready, cmd_abort, pio_rd_start, dma_rd_start;
	logic wr_start, native_max_valid, trim_done, sec_erase_done;
	logic defaults_restored, wr_ready, wr_ack, rd_valid, rd_corrected;
	logic rd_uncorr, fl_req_valid, fl_req_ready, fl_done, fl_fail;
	logic phy_pwr_on, phy_tx_en, phy_rx_en, phy_ready, bad_use;
	logic fl_congested;
	logic [7:0] cmd_opcode, err_inj, fl_err_bits;
	logic [47:0] cmd_lba, native_max_lba;
	logic [15:0] cmd_count;
	logic [31:0] wr_data, rd_data, fl_req_data, fl_rd_data;
	logic [3:0] fbad_blk, fl_req_blk, e_blk;
	logic [24:0] xfer_bytes;
	logic [56:0] xfer_addr;
	logic [1:0] fl_req_op, last_op;
	logic [2:0] link_state;
	logic [4:0] ev;
	int failures, checks_done, n_pdone, n_ones, n_erase, n_fail, base, n;
	// {opcode, pio, dma, native max, abort}
	localparam logic [11:0] ROWS [11] = '{12'h208, 12'h218, 12'h248,
		12'h254, 12'hC84, 12'hC94, 12'h272, 12'h101, 12'h311, 12'hE71,
		12'h001};
	assign ev = {link_state == 3'h0, trim_done, sec_erase_done, wr_ack,
		rd_valid | rd_uncorr};
	scpm_core #(.DIPM_IDLE(16'h0010)) i_scpm_core (.core_clk, .rst,
		.cmd_valid, .cmd_opcode, .cmd_lba, .cmd_count, .cmd_ready,
		.cmd_abort, .pio_rd_start, .dma_rd_start, .wr_start, .xfer_bytes,
		.xfer_addr, .native_max_valid, .native_max_lba, .trim_done,
		.sec_erase_done, .defaults_restored, .wr_valid, .wr_data, .wr_last,
		.wr_ready, .wr_ack, .rd_valid, .rd_data, .rd_corrected, .rd_uncorr,
		.fbad_valid, .fbad_blk, .fl_req_valid, .fl_req_op, .fl_req_blk,
		.fl_req_data, .fl_req_ready, .fl_done, .fl_fail, .fl_err_bits,
		.fl_rd_data, .fl_congested, .hipm_partial, .hipm_slumber,
		.dipm_en, .host_wake, .dev_wake, .devslp_pin, .phy_pwr_on,
		.phy_tx_en, .phy_rx_en, .phy_ready, .link_state);
	scpm_flash_model i_scpm_flash_model (.core_clk, .rst, .slow, .err_inj,
		.fl_req_valid, .fl_req_op, .fl_req_blk, .fl_req_ready, .fl_done,
		.fl_fail, .fl_err_bits, .fl_rd_data);
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			{bad_use, last_op} <= '0;
			{n_pdone, n_ones, n_erase, n_fail} <= '0;
		end
		else
		begin
			if (fl_req_valid && fl_req_ready)
			begin
				last_op <= fl_req_op;
				// block 3 fails in the model and must not be reused
				if (fl_req_op == 2'h1 && (fl_req_blk == 4'h0 ||
					(fl_req_blk == 4'h3 && n_fail != 0)))
					bad_use <= 1'b1;
				if (fl_req_op == 2'h1 && fl_req_data == 32'hFFFF_FFFF)
					n_ones <= n_ones + 1;
				if (fl_req_op == 2'h2)
				begin
					n_erase <= n_erase + 1;
					e_blk <= fl_req_blk;
				end
			end
			if (fl_done && fl_fail)
				n_fail <= n_fail + 1;
			if (fl_done && !fl_fail && last_op == 2'h1)
				n_pdone <= n_pdone + 1;
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_ev(input int b, input int lim);
		n = 0;
		while (ev[b] !== 1'b1 && n < lim)
		begin
			n++;
			@(negedge core_clk);
		end
		chk(64'(ev[b]), 64'h1);
	endtask
	// one idle edge first so back-to-back calls never merge into one long cmd_valid pulse
	task automatic cmd(input logic [7:0] op, input logic [47:0] lba,
		input logic [15:0] cnt);
		@(negedge core_clk);
		n = 0;
		while (cmd_ready !== 1'b1 && n < 20000)
		begin
			n++;
			@(negedge core_clk);
		end
		{cmd_opcode, cmd_lba, cmd_count} = {op, lba, cnt};
		cmd_valid = 1'b1;
		@(negedge core_clk);
		cmd_valid = 1'b0;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial
	begin
		#400000;
		failures++;
		final_report;
	end
	initial
	begin
		{cmd_valid, wr_valid, wr_last, fbad_valid, slow, dipm_en} = '0;
		fl_congested = 1'b0;
		{hipm_partial, hipm_slumber, host_wake, dev_wake, devslp_pin} = '0;
		{cmd_opcode, cmd_lba, cmd_count, wr_data, fbad_blk, err_inj} = '0;
		{failures, checks_done} = '0;
		rst = 1'b1;
		repeat (20) @(negedge core_clk);
		chk({link_state, phy_pwr_on, phy_tx_en, phy_rx_en, phy_ready,
			wr_ready}, {3'h0, 5'h1F});
		rst = 1'b0;
		fbad_valid = 1'b1;
		@(negedge core_clk);
		fbad_valid = 1'b0;
		err_inj = 8'h48;
		foreach (ROWS[i])
		begin
			slow = i[0];
			cmd(ROWS[i][11:4], 48'h300, 16'h2);
			chk({pio_rd_start, dma_rd_start, native_max_valid, cmd_abort},
				ROWS[i][3:0]);
			if (ROWS[i][3:2] != 2'h0)
			begin
				chk(xfer_bytes, 64'h400);
				chk(xfer_addr, 64'h6_0000);
				wait_ev(0, 200);
				chk({rd_valid, rd_corrected, rd_data},
					{2'h3, 32'hD000_0003});
			end
		end
		chk(native_max_lba, 64'h1DD_40AF);
		err_inj = 8'h49;
		cmd(8'h20, 48'h300, 16'h1);
		wait_ev(0, 200);
		chk(rd_uncorr, 1'b1);
		chk(rd_valid && rd_data === 32'hD000_0003, 1'b0);
		// grouping off first: a lone word must drain despite congestion
		cmd(8'hEF, 48'h0, 16'h0);
		fl_congested = 1'b1;
		cmd(8'h30, 48'h0, 16'h4);
		chk(wr_start, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			if (k == 1 || k == 3)
			begin
				wr_valid = 1'b0;
				repeat (40) @(negedge core_clk);
				chk(n_pdone, 1);
				if (k == 1)
					cmd(8'hEF, 48'h0, 16'h1);
			end
			while (wr_ready !== 1'b1)
				@(negedge core_clk);
			{wr_valid, wr_data, wr_last} = {1'b1, 32'(k), k == 3};
			@(negedge core_clk);
		end
		{wr_valid, wr_last} = '0;
		wait_ev(1, 2000);
		fl_congested = 1'b0;
		chk(n_pdone, 4);
		chk({bad_use, 32'(n_fail)}, {1'b0, 32'h1});
		base = n_ones;
		cmd(8'hF4, 48'h0, 16'h0);
		wait_ev(2, 5000);
		chk(defaults_restored, 1'b1);
		chk(n_ones - base, 14);
		base = n_erase;
		cmd(8'h06, 48'h200, 16'h1);
		wait_ev(3, 500);
		chk({e_blk, 32'(n_erase - base)}, {4'h2, 32'h1});
		cmd(8'h06, 48'h0, 16'h1);
		wait_ev(3, 3);
		chk(n_erase - base, 1);
		hipm_partial = 1'b1;
		repeat (8) @(negedge core_clk);
		hipm_partial = 1'b0;
		chk({link_state, cmd_ready}, {3'h1, 1'b0});
		host_wake = 1'b1;
		wait_ev(4, 2499);
		host_wake = 1'b0;
		chk({phy_pwr_on, phy_tx_en, phy_rx_en, phy_ready}, 4'hF);
		hipm_slumber = 1'b1;
		repeat (8) @(negedge core_clk);
		hipm_slumber = 1'b0;
		chk(link_state, 3'h2);
		dev_wake = 1'b1;
		wait_ev(4, 2499999);
		dev_wake = 1'b0;
		dipm_en = 1'b1;
		repeat (40) @(negedge core_clk);
		dipm_en = 1'b0;
		chk(link_state, 3'h1);
		dev_wake = 1'b1;
		wait_ev(4, 2499);
		dev_wake = 1'b0;
		devslp_pin = 1'b1;
		repeat (8) @(negedge core_clk);
		chk({link_state, phy_pwr_on}, {3'h3, 1'b0});
		devslp_pin = 1'b0;
		wait_ev(4, 5000000);
		final_report;
	end
endmodule
`default_nettype wire

//--- tb/scpm_flash_model.sv
// behavioural flash array answering one request at a time
`default_nettype none
module scpm_flash_model #(
	parameter int BW = 4,
	parameter int LAT = 3,
	// every program to this block fails, so it grows bad in use
	parameter int FAIL_BLK = 3
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [7:0] err_inj,
	input wire logic fl_req_valid,
	input wire logic [1:0] fl_req_op,
	input wire logic [BW-1:0] fl_req_blk,
	output logic fl_req_ready,
	output logic fl_done,
	output logic fl_fail,
	output logic [7:0] fl_err_bits,
	output logic [31:0] fl_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_ff;
	logic [7:0] cnt_ff;
	logic [1:0] op_ff;
	logic [BW-1:0] blk_ff;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			{busy_ff, cnt_ff, op_ff, blk_ff} <= '0;
			{fl_req_ready, fl_done, fl_fail, fl_err_bits} <= '0;
			fl_rd_data <= 32'h0000_0000;
		end
		else
		begin
			fl_req_ready <= 1'b0;
			fl_done <= 1'b0;
			fl_fail <= 1'b0;
			// outside a done pulse fl_err_bits and fl_rd_data toggle, never hold old data
			fl_err_bits <= ~fl_err_bits;
			fl_rd_data <= ~fl_rd_data;
			cnt_ff <= cnt_ff + 8'h01;
			if (!busy_ff && !fl_req_valid)
				cnt_ff <= 8'h00;
			else if (!busy_ff && !fl_req_ready)
			begin
				if (cnt_ff >= (slow ? 8'h10 : 8'h00))
				begin
					fl_req_ready <= 1'b1;
					busy_ff <= 1'b1;
					cnt_ff <= 8'h00;
					op_ff <= fl_req_op;
					blk_ff <= fl_req_blk;
				end
			end
			else if (busy_ff && cnt_ff == 8'(LAT))
			begin
				busy_ff <= 1'b0;
				fl_done <= 1'b1;
				fl_fail <= op_ff == 2'h1 && blk_ff == BW'(FAIL_BLK);
				fl_err_bits <= (op_ff == 2'h0) ? err_inj : 8'h00;
				fl_rd_data <= {28'hD00_0000, 4'(blk_ff)};
			end
		end
	end
endmodule
`default_nettype wire
